// File: rtl/tuid_consts.svh
`ifndef TUID_CONSTS_SVH
`define TUID_CONSTS_SVH
// Notes on behaviour
// - Both capability registers are 32-bit read-only words; reset contents unspecified.
// - Bit 31 of register 0 reports two security states; non-secure reads see zero.
// - Stage 1, stage 2, nested bits separate; nested set forces both stage bits set.
// - Match-lookup bit 1 means match registers; 0 means stream indexing.
// - Translation-ops-absent bit reads 0 whenever stage 1 support reads 0.
// - Legacy format field: 00 both, 01 long only, 10 none, 11 reserved.
// - Non-secure reads of irq count return the secure-set override on two-state parts.
// - Extended match bit: secure reads 1, non-secure reads inverse of disable, else 0.
// - Bit 14 coherent walk support, bit 13 broadcast TLB maintenance support.
// - Stream id width gives bit count 0-15, or 15 when wide ids supported.
// - Wide stream id bit set means 16-bit ids; width field then reads maximum.
// - Mapping group count 0-128; secure read returns 128 with extended matching.
// - Non-secure read of group count returns secure-set override on two-state parts.
// - Bit 31 of register 1 gives page size: 0 4KB, 1 64KB.
// - Page index field: page count is two to the field plus one.
// - Flag update field: 00 none, 01 access flag, 11 access and dirty.
// - Stage-2-only bank count 0-128, meaningful only with stage 2 support.
// - Match conflict bit reads 1 when detection of every conflict is guaranteed.
// - Descriptor table field 00/01/11, 10 reserved; non-secure reads return zero on two-state parts.
// - Descriptor index width gives index bits; all ones with extended table.
// - Non-secure reads of descriptor index width return zero on two-state parts.
// - Low byte of register 1 is bank count; non-secure reads return the override on two-state parts.
`define TUID_ADDR_W 4
`define TUID_OFF_CAP0 4'h0
`define TUID_OFF_CAP1 4'h4
`define TUID_OFF_SCFG 4'h8
`define TUID_BIT_SES 31
`define TUID_BIT_S1 30
`define TUID_BIT_S2 29
`define TUID_BIT_NEST 28
`define TUID_BIT_SMS 27
`define TUID_BIT_ATOS 26
`define TUID_POS_LEGACY_FORMAT_SUPPORT 24
`define TUID_POS_IRQ 16
`define TUID_BIT_EXSM 15
`define TUID_BIT_COHERENT_WALK_SUPPORT 14
`define TUID_BIT_BTM 13
`define TUID_POS_SIDB 9
`define TUID_BIT_EXID 8
`define TUID_POS_SMRG 0
`define TUID_BIT_PAGE 31
`define TUID_POS_PNDX 28
`define TUID_POS_HAF 24
`define TUID_POS_S2CB 16
`define TUID_BIT_CONF 14
`define TUID_POS_SSDT 12
`define TUID_POS_SSDN 8
`define TUID_POS_CONTEXT_BANK_COUNT 0
`define TUID_SMRG_EXT 8'h80
`define TUID_SIDB_MAX 4'hF
`define TUID_SSDN_MAX 4'hF
`define TUID_SSDT_EXT 2'h3
`define TUID_SCFG_RESET 32'h0000_0000
`endif

// File: rtl/tuid_pkg.sv
package tuid_pkg;
	typedef logic [31:0] tuid_word_t;
	typedef logic [7:0] tuid_count_t;
endpackage

// File: rtl/tuid_regs.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "tuid_consts.svh"
module tuid_regs #(
	parameter bit P_SES = 1'b1,
	parameter bit P_S1 = 1'b1,
	parameter bit P_S2 = 1'b1,
	parameter bit P_NEST = 1'b1,
	parameter bit P_SMS = 1'b1,
	parameter bit P_ATOS_ABSENT = 1'b0,
	parameter logic [1:0] P_LEGACY_FORMAT_SUPPORT = 2'h1,
	parameter logic [7:0] P_IRQ = 8'h08,
	parameter bit P_EXSM = 1'b0,
	parameter bit P_COHERENT_WALK_SUPPORT = 1'b1,
	parameter bit P_BTM = 1'b1,
	parameter logic [3:0] P_SIDB = 4'hA,
	parameter bit P_EXID = 1'b0,
	parameter logic [7:0] P_SMRG = 8'h20,
	parameter bit P_PAGE64 = 1'b0,
	parameter logic [2:0] P_PNDX = 3'h3,
	parameter logic [1:0] P_HAF = 2'h3,
	parameter logic [7:0] P_S2CB = 8'h04,
	parameter bit P_CONF = 1'b1,
	parameter logic [1:0] P_SSDT = 2'h1,
	parameter logic [3:0] P_SSDN = 4'h6,
	parameter logic [7:0] P_CONTEXT_BANK_COUNT = 8'h10
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [`TUID_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic secure,
	output tuid_pkg::tuid_word_t rdata
);
	import tuid_pkg::*;

	// Secure override config: [7:0] irq, [15:8] groups, [23:16] banks, [24] ext disable
	tuid_word_t scfg_reg;
	tuid_word_t rdata_reg;
	tuid_word_t cap0;
	tuid_word_t cap1;
	tuid_word_t rdata_next;
	logic ns;

	// Nested support implies both stage bits
	localparam bit S1_EFF = P_S1 | P_NEST;
	localparam bit S2_EFF = P_S2 | P_NEST;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scfg_reg <= `TUID_SCFG_RESET;
			scfg_reg[7:0] <= P_IRQ;
			scfg_reg[15:8] <= P_SMRG;
			scfg_reg[23:16] <= P_CONTEXT_BANK_COUNT;
		end else if (wr && secure && addr == `TUID_OFF_SCFG) begin
			scfg_reg <= {7'h00, wdata[24:0]};
		end
	end

	assign ns = P_SES & ~secure;

	always_comb begin
		cap0 = '0;
		cap0[`TUID_BIT_SES] = P_SES & secure;
		cap0[`TUID_BIT_S1] = S1_EFF;
		cap0[`TUID_BIT_S2] = S2_EFF;
		cap0[`TUID_BIT_NEST] = P_NEST;
		cap0[`TUID_BIT_SMS] = P_SMS;
		cap0[`TUID_BIT_ATOS] = P_ATOS_ABSENT & S1_EFF;
		cap0[`TUID_POS_LEGACY_FORMAT_SUPPORT +: 2] = P_LEGACY_FORMAT_SUPPORT;
		cap0[`TUID_POS_IRQ +: 8] = ns ? scfg_reg[7:0] : P_IRQ;
		if (P_EXSM) begin
			cap0[`TUID_BIT_EXSM] = secure | ~scfg_reg[24];
		end
		cap0[`TUID_BIT_COHERENT_WALK_SUPPORT] = P_COHERENT_WALK_SUPPORT;
		cap0[`TUID_BIT_BTM] = P_BTM;
		cap0[`TUID_POS_SIDB +: 4] = P_EXID ? `TUID_SIDB_MAX : P_SIDB;
		cap0[`TUID_BIT_EXID] = P_EXID;
		if (ns) begin
			cap0[`TUID_POS_SMRG +: 8] = scfg_reg[15:8];
		end else if (P_EXSM) begin
			cap0[`TUID_POS_SMRG +: 8] = `TUID_SMRG_EXT;
		end else begin
			cap0[`TUID_POS_SMRG +: 8] = P_SMRG;
		end
		cap1 = '0;
		cap1[`TUID_BIT_PAGE] = P_PAGE64;
		cap1[`TUID_POS_PNDX +: 3] = P_PNDX;
		cap1[`TUID_POS_HAF +: 2] = P_HAF;
		cap1[`TUID_POS_S2CB +: 8] = S2_EFF ? P_S2CB : 8'h00;
		cap1[`TUID_BIT_CONF] = P_CONF;
		cap1[`TUID_POS_SSDT +: 2] = ns ? 2'h0 : P_SSDT;
		if (ns) begin
			cap1[`TUID_POS_SSDN +: 4] = 4'h0;
		end else if (P_SSDT == `TUID_SSDT_EXT) begin
			cap1[`TUID_POS_SSDN +: 4] = `TUID_SSDN_MAX;
		end else begin
			cap1[`TUID_POS_SSDN +: 4] = P_SSDN;
		end
		cap1[`TUID_POS_CONTEXT_BANK_COUNT +: 8] = ns ? scfg_reg[23:16] : P_CONTEXT_BANK_COUNT;
		case (addr)
			`TUID_OFF_CAP0: rdata_next = cap0;
			`TUID_OFF_CAP1: rdata_next = cap1;
			`TUID_OFF_SCFG: rdata_next = secure ? scfg_reg : 32'h0000_0000;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	assign rdata = rdata_reg;
endmodule

// File: dv/tuid_regs_checker.sv
`timescale 1ns/1ps
module tuid_regs_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic rd,
	input wire logic secure,
	input wire logic [31:0] rdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
	chk_ns_ses: assert property (rd && !secure && addr == 4'h0 |=> !rdata[31]) else $error("ses");
	chk_nest_stages: assert property (rd && addr == 4'h0 |=> !rdata[28] || &rdata[30:29])
		else $error("nest without stages");
	chk_ops_stage: assert property (rd && addr == 4'h0 |=> rdata[30] || !rdata[26])
		else $error("ops bit without stage 1");
	chk_fmt_legal: assert property (rd && addr == 4'h0 |=> rdata[25:24] != 2'h3)
		else $error("format reserved");
	chk_wide_width: assert property (rd && addr == 4'h0 |=> !rdata[8] || rdata[12:9] == 4'hF)
		else $error("width not max");
	chk_flag_legal: assert property (rd && addr == 4'h4 |=> rdata[25:24] != 2'h2 && rdata[27:26] == 2'h0)
		else $error("flag field bad");
	chk_ns_table: assert property (rd && !secure && addr == 4'h4 |=> rdata[13:8] == 6'h0)
		else $error("table visible");
	chk_ext_table: assert property (rd && addr == 4'h4 |=> rdata[13:12] != 2'h2 && (rdata[13:12] != 2'h3 || rdata[11:8] == 4'hF))
		else $error("table field bad");
endmodule
bind tuid_regs tuid_regs_checker tuid_regs_checker_i (.clk_sys(clk_sys), .rst(rst), .addr(addr),
	.rd(rd), .secure(secure), .rdata(rdata));

// File: dv/tuid_regs_tb.sv
`timescale 1ns/1ps
module tuid_regs_tb;
	import tuid_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	tuid_word_t wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic secure = 1'b0;
	tuid_word_t rdata;
	int n_mismatch = 0;
	int n_compared = 0;
	tuid_regs tuid_regs_i (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .secure(secure), .rdata(rdata));
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic complete_run;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic put(input logic [3:0] a, input tuid_word_t d, input logic s);
		@(posedge clk_sys);
		{wr, addr, wdata, secure} <= {1'b1, a, d, s};
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic check(input tuid_word_t seen, input tuid_word_t e, input string n);
		n_compared++;
		if (seen !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, seen);
		end
	endtask
	task automatic get(input logic [3:0] a, input logic s, input tuid_word_t e, input string n);
		@(posedge clk_sys);
		{rd, addr, secure} <= {1'b1, a, s};
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		check(rdata, e, n);
		@(posedge clk_sys);
		#1;
		check(rdata, 32'h0000_0000, "idle");
	endtask
	initial begin
		#20000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		get(4'h0, 1'b1, 32'hF908_7420, "cap0_s");
		get(4'h4, 1'b1, 32'h3304_5610, "cap1_s");
		get(4'h0, 1'b0, 32'h7908_7420, "cap0_ns");
		get(4'h4, 1'b0, 32'h3304_4010, "cap1_ns");
		put(4'h0, 32'hFFFF_FFFF, 1'b1);
		put(4'h4, 32'hFFFF_FFFF, 1'b1);
		put(4'h8, 32'h0155_4433, 1'b0);
		get(4'h0, 1'b1, 32'hF908_7420, "cap0_wr");
		get(4'h4, 1'b1, 32'h3304_5610, "cap1_wr");
		get(4'h0, 1'b0, 32'h7908_7420, "cap0_nsw");
		get(4'h8, 1'b0, 32'h0, "cfg_ns");
		get(4'hC, 1'b1, 32'h0, "unmapped");
		put(4'h8, 32'h0155_4433, 1'b1);
		get(4'h8, 1'b1, 32'h0155_4433, "cfg_s");
		get(4'h0, 1'b0, 32'h7933_7444, "cap0_ovr");
		get(4'h4, 1'b0, 32'h3304_4055, "cap1_ovr");
		get(4'h0, 1'b1, 32'hF908_7420, "cap0_s2");
		complete_run();
	end
endmodule
